/* File: src/cwx_pkg.sv */
// Constants, types and window layout for the processor-side window decoder crossbar.
package cwx_pkg;

  localparam int CWX_ADDR_W = 36;
  localparam int CWX_DATA_W = 64;
  localparam int CWX_BE_W   = 8;
  localparam int CWX_NWIN   = 21;
  localparam int CWX_NUNIT  = 6;
  localparam int CWX_NPCI   = 2;
  localparam int CWX_NCPU   = 2;
  localparam int CWX_NDEV   = 5;

  // Outstanding pipelined transactions allowed per processor.
  localparam logic [3:0] CWX_MAX_OUTST = 4'h8;

  // Window numbering: the lowest matching number wins.
  localparam logic [4:0] CWX_WIN_DRAM0  = 5'h00;
  localparam logic [4:0] CWX_WIN_DEV0   = 5'h04;
  localparam logic [4:0] CWX_WIN_PCI0   = 5'h09;
  localparam logic [4:0] CWX_WIN_PCI1   = 5'h0e;
  localparam logic [4:0] CWX_WIN_SRAM   = 5'h13;
  localparam logic [4:0] CWX_WIN_REG    = 5'h14;
  localparam logic [4:0] CWX_WIN_IO_OFS = 5'h04;

  // Device bank numbering; bank four is the boot bank.
  localparam logic [2:0] CWX_DEV_BANK1 = 3'h1;
  localparam logic [2:0] CWX_DEV_BOOT  = 3'h4;

  // Fixed 256KB SRAM window and 512MB ceiling of a device bank, as size minus one.
  localparam logic [35:0] CWX_SRAM_SIZE_M1 = 36'h0_0003_ffff;
  localparam logic [35:0] CWX_DEV_SIZE_M1  = 36'h0_1fff_ffff;

  typedef enum logic [2:0] {
    CWX_U_DRAM = 3'b000,
    CWX_U_DEV  = 3'b001,
    CWX_U_PCI0 = 3'b010,
    CWX_U_PCI1 = 3'b011,
    CWX_U_SRAM = 3'b100,
    CWX_U_REG  = 3'b101
  } cwx_unit_e;

  typedef enum logic [1:0] {
    CWX_MST_CPU  = 2'b00,
    CWX_MST_PCI0 = 2'b01,
    CWX_MST_PCI1 = 2'b10
  } cwx_mst_e;

  typedef enum logic [1:0] {
    CWX_W8  = 2'b00,
    CWX_W16 = 2'b01,
    CWX_W32 = 2'b10,
    CWX_W64 = 2'b11
  } cwx_width_e;

  typedef struct packed {
    cwx_width_e width;
    logic       parity_en;
    logic [3:0] wait_cyc;
  } cwx_dev_par_s;

  localparam cwx_dev_par_s CWX_DEV_PAR_RST32 = '{width: CWX_W32, parity_en: 1'b0,
                                                 wait_cyc: 4'hf};
  localparam cwx_dev_par_s CWX_DEV_PAR_RST8  = '{width: CWX_W8, parity_en: 1'b0,
                                                 wait_cyc: 4'hf};

  typedef struct packed {
    logic                  en;
    logic [CWX_ADDR_W-1:0] base;
    logic [31:0]           size_m1;
  } cwx_win_cfg_s;

  typedef struct packed {
    logic [CWX_ADDR_W-1:0] addr;
    logic [CWX_DATA_W-1:0] wdata;
    logic [CWX_BE_W-1:0]   be;
    logic                  we;
    logic                  cpu;
  } cwx_req_s;

  typedef struct packed {
    cwx_req_s     req;
    cwx_mst_e     mst;
    logic [4:0]   win;
    logic         io;
    cwx_dev_par_s dpar;
  } cwx_tgt_req_s;

  typedef struct packed {
    logic [CWX_DATA_W-1:0] rdata;
    logic                  err;
    cwx_mst_e              mst;
    logic                  cpu;
  } cwx_rsp_s;

endpackage

/* File: src/cwx_xbar.sv */
// Processor-side address window decoder and crossbar toward the target units.
//
// Behaviour
// - Master and slave roles, one bus clock
// - 36-bit address, 64-bit data, full decode
// - Eight outstanding per processor, then stall
// - Exactly 21 decode windows, one target each
// - Four windows select DRAM chip selects
// - Five windows select device chip selects
// - Each PCI port: four memory, one I/O
// - One SRAM window, one register window
// - Programmable base and size, up to 4GB
// - SRAM window fixed at 256KB
// - Up to five device banks
// - Each device bank spans up to 512MB
// - Per-bank parameter register shapes bank cycles
// - Boot bank, bank zero: 32-bit, no parity
// - Bank one: 8-bit, no parity
// - Different unit pairs transfer concurrently
// - Register space reachable from processor and PCI
`timescale 1ns/1ns
module cwx_xbar (
  input  logic                 ref_clk,
  input  logic                 rst,
  input  logic                 cpu_req_valid,
  output logic                 cpu_req_ready,
  input  cwx_pkg::cwx_req_s    cpu_req,
  output logic                 cpu_rsp_valid,
  input  logic                 cpu_rsp_ready,
  output cwx_pkg::cwx_rsp_s    cpu_rsp,
  input  logic                 mst_in_valid,
  output logic                 mst_in_ready,
  input  cwx_pkg::cwx_req_s    mst_in,
  output logic                 cpu_mst_valid,
  input  logic                 cpu_mst_ready,
  output cwx_pkg::cwx_req_s    cpu_mst,
  input  logic                 pci_req_valid [cwx_pkg::CWX_NPCI],
  output logic                 pci_req_ready [cwx_pkg::CWX_NPCI],
  input  cwx_pkg::cwx_req_s    pci_req       [cwx_pkg::CWX_NPCI],
  output logic                 pci_rsp_valid [cwx_pkg::CWX_NPCI],
  input  logic                 pci_rsp_ready [cwx_pkg::CWX_NPCI],
  output cwx_pkg::cwx_rsp_s    pci_rsp       [cwx_pkg::CWX_NPCI],
  input  cwx_pkg::cwx_win_cfg_s win_cfg      [cwx_pkg::CWX_NWIN],
  input  logic                 dev_par_we,
  input  logic [2:0]           dev_par_idx,
  input  cwx_pkg::cwx_dev_par_s dev_par_wdata,
  output cwx_pkg::cwx_dev_par_s dev_par     [cwx_pkg::CWX_NDEV],
  output logic                 tgt_valid     [cwx_pkg::CWX_NUNIT],
  input  logic                 tgt_ready     [cwx_pkg::CWX_NUNIT],
  output cwx_pkg::cwx_tgt_req_s tgt_req     [cwx_pkg::CWX_NUNIT],
  input  logic                 tgt_rsp_valid [cwx_pkg::CWX_NUNIT],
  output logic                 tgt_rsp_ready [cwx_pkg::CWX_NUNIT],
  input  cwx_pkg::cwx_rsp_s    tgt_rsp       [cwx_pkg::CWX_NUNIT],
  input  logic                 unmapped_clr,
  output logic                 unmapped
);
  import cwx_pkg::*;

  logic [CWX_NWIN-1:0]  hit_vec;
  logic [4:0]           win_sel;
  logic                 miss;
  cwx_unit_e            cpu_unit;
  cwx_tgt_req_s         cpu_tgt;
  cwx_dev_par_s         cpu_dpar;
  logic [2:0]           cpu_bank;
  logic                 cnt_ok;
  logic                 cpu_take;
  logic                 cpu_reg_take;
  logic [CWX_NUNIT-1:0] load;
  logic [CWX_NUNIT-1:0] slot_free;
  logic [CWX_NPCI-1:0]  pci_take;
  logic                 cpu_rsp_load;
  logic [CWX_NUNIT-1:0] cpu_gnt;
  cwx_rsp_s             cpu_gnt_rsp;
  logic [CWX_NPCI-1:0]  pci_rsp_load;
  logic                 err_pend_reg;
  logic                 err_cpu_reg;
  logic                 unmapped_reg;
  logic [3:0]           outst_reg     [CWX_NCPU];
  cwx_dev_par_s         dev_par_reg   [CWX_NDEV];
  logic                 tgt_valid_reg [CWX_NUNIT];
  cwx_tgt_req_s         tgt_req_reg   [CWX_NUNIT];
  logic                 cpu_rsp_valid_reg;
  cwx_rsp_s             cpu_rsp_reg;
  logic                 pci_rsp_valid_reg [CWX_NPCI];
  cwx_rsp_s             pci_rsp_reg       [CWX_NPCI];
  logic                 cpu_mst_valid_reg;
  cwx_req_s             cpu_mst_reg;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  function automatic cwx_unit_e unit_of(input logic [4:0] w);
    if (w < CWX_WIN_DEV0) return CWX_U_DRAM;
    if (w < CWX_WIN_PCI0) return CWX_U_DEV;
    if (w < CWX_WIN_PCI1) return CWX_U_PCI0;
    if (w < CWX_WIN_SRAM) return CWX_U_PCI1;
    if (w == CWX_WIN_SRAM) return CWX_U_SRAM;
    return CWX_U_REG;
  endfunction

  // Every window compares the full 36-bit address against base and base plus size.
  for (genvar gi = 0; gi < CWX_NWIN; gi++) begin : g_win
    logic [CWX_ADDR_W-1:0] ofs;
    logic [CWX_ADDR_W-1:0] lim;
    assign ofs = cpu_req.addr - win_cfg[gi].base;
    if (gi == int'(CWX_WIN_SRAM)) begin : g_sram
      assign lim = CWX_SRAM_SIZE_M1;
      sram_span_a: assert property (hit_vec[gi] |-> ofs <= CWX_SRAM_SIZE_M1)
        else $error("SRAM window matched beyond its fixed size");
    end else if (gi >= int'(CWX_WIN_DEV0) && gi < int'(CWX_WIN_PCI0)) begin : g_dev
      assign lim = ({4'h0, win_cfg[gi].size_m1} > CWX_DEV_SIZE_M1) ?
                   CWX_DEV_SIZE_M1 : {4'h0, win_cfg[gi].size_m1};
      dev_span_a: assert property (hit_vec[gi] |-> ofs <= CWX_DEV_SIZE_M1)
        else $error("Device window matched beyond a bank span");
    end else begin : g_gen
      assign lim = {4'h0, win_cfg[gi].size_m1};
    end
    assign hit_vec[gi] = win_cfg[gi].en && (cpu_req.addr >= win_cfg[gi].base) &&
                         (ofs <= lim);
  end

  // The lowest numbered matching window is the only one taken.
  always_comb begin
    win_sel = CWX_WIN_DRAM0;
    miss    = 1'b1;
    for (int i = CWX_NWIN - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        win_sel = 5'(i);
        miss    = 1'b0;
      end
    end
  end

  assign cpu_unit = unit_of(win_sel);
  assign cpu_bank = 3'(win_sel - CWX_WIN_DEV0);
  assign cpu_dpar = (cpu_unit == CWX_U_DEV) ? dev_par_reg[cpu_bank] : '0;

  always_comb begin
    cpu_tgt      = '0;
    cpu_tgt.req  = cpu_req;
    cpu_tgt.mst  = CWX_MST_CPU;
    cpu_tgt.win  = win_sel;
    cpu_tgt.io   = (win_sel == CWX_WIN_PCI0 + CWX_WIN_IO_OFS) ||
                   (win_sel == CWX_WIN_PCI1 + CWX_WIN_IO_OFS);
    cpu_tgt.dpar = cpu_dpar;
  end

  // Device bank parameters; bank one is byte wide, the others 32-bit, none with parity.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int b = 0; b < CWX_NDEV; b++) begin
        dev_par_reg[b] <= (b == int'(CWX_DEV_BANK1)) ? CWX_DEV_PAR_RST8 :
                          CWX_DEV_PAR_RST32;
      end
    end else if (dev_par_we && dev_par_idx <= CWX_DEV_BOOT) begin
      dev_par_reg[dev_par_idx] <= dev_par_wdata;
    end
  end

  // Address phases stall once a processor has eight transactions open.
  assign cnt_ok        = outst_reg[cpu_req.cpu] != CWX_MAX_OUTST;
  assign cpu_req_ready = cnt_ok && (miss ? !err_pend_reg : slot_free[cpu_unit]);
  assign cpu_take      = cpu_req_valid && cpu_req_ready;
  assign cpu_reg_take  = cpu_take && !miss && cpu_unit == CWX_U_REG;

  for (genvar gc = 0; gc < CWX_NCPU; gc++) begin : g_cnt
    logic inc;
    logic dec;
    assign inc = cpu_take && cpu_req.cpu == 1'(gc);
    assign dec = cpu_rsp_valid_reg && cpu_rsp_ready && cpu_rsp_reg.cpu == 1'(gc);
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        outst_reg[gc] <= 4'h0;
      end else begin
        outst_reg[gc] <= outst_reg[gc] + 4'(inc) - 4'(dec);
      end
    end
  end

  // The register space takes the processor first, then PCI port 0, then port 1.
  assign pci_req_ready[0] = slot_free[CWX_U_REG] && !cpu_reg_take;
  assign pci_req_ready[1] = slot_free[CWX_U_REG] && !cpu_reg_take && !pci_req_valid[0];
  assign pci_take[0]      = pci_req_valid[0] && pci_req_ready[0];
  assign pci_take[1]      = pci_req_valid[1] && pci_req_ready[1];

  // Each unit has its own slot, so different units load in the same cycle.
  for (genvar gu = 0; gu < CWX_NUNIT; gu++) begin : g_unit
    cwx_tgt_req_s nxt;
    assign slot_free[gu] = !tgt_valid_reg[gu] || tgt_ready[gu];
    if (gu == int'(CWX_U_REG)) begin : g_reg
      assign load[gu] = cpu_reg_take || (|pci_take);
      always_comb begin
        nxt = cpu_tgt;
        if (!cpu_reg_take) begin
          nxt     = '0;
          nxt.req = pci_take[0] ? pci_req[0] : pci_req[1];
          nxt.mst = pci_take[0] ? CWX_MST_PCI0 : CWX_MST_PCI1;
          nxt.win = CWX_WIN_REG;
        end
      end
    end else begin : g_oth
      assign load[gu] = cpu_take && !miss && cpu_unit == cwx_unit_e'(gu);
      assign nxt      = cpu_tgt;
    end
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        tgt_valid_reg[gu] <= 1'b0;
        tgt_req_reg[gu]   <= '0;
      end else if (load[gu]) begin
        tgt_valid_reg[gu] <= 1'b1;
        tgt_req_reg[gu]   <= nxt;
      end else if (tgt_ready[gu]) begin
        tgt_valid_reg[gu] <= 1'b0;
      end
    end
    assign tgt_valid[gu] = tgt_valid_reg[gu];
    assign tgt_req[gu]   = tgt_req_reg[gu];
  end

  // An unmapped access is answered here with an error and never reaches a unit.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      err_pend_reg <= 1'b0;
      err_cpu_reg  <= 1'b0;
    end else if (cpu_take && miss) begin
      err_pend_reg <= 1'b1;
      err_cpu_reg  <= cpu_req.cpu;
    end else if (cpu_rsp_load) begin
      err_pend_reg <= 1'b0;
    end
  end

  // A new miss in the clearing cycle keeps the flag set.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      unmapped_reg <= 1'b0;
    end else if (cpu_take && miss) begin
      unmapped_reg <= 1'b1;
    end else if (unmapped_clr) begin
      unmapped_reg <= 1'b0;
    end
  end

  // Response return: the local error first, then the lowest numbered unit.
  assign cpu_rsp_load    = !cpu_rsp_valid_reg || cpu_rsp_ready;
  assign pci_rsp_load[0] = !pci_rsp_valid_reg[0] || pci_rsp_ready[0];
  assign pci_rsp_load[1] = !pci_rsp_valid_reg[1] || pci_rsp_ready[1];

  always_comb begin
    logic found;
    found       = err_pend_reg;
    cpu_gnt     = '0;
    cpu_gnt_rsp = '0;
    for (int u = 0; u < CWX_NUNIT; u++) begin
      tgt_rsp_ready[u] = 1'b0;
      if (tgt_rsp_valid[u] && tgt_rsp[u].mst == CWX_MST_CPU) begin
        if (!found && cpu_rsp_load) begin
          found            = 1'b1;
          cpu_gnt[u]       = 1'b1;
          cpu_gnt_rsp      = tgt_rsp[u];
          tgt_rsp_ready[u] = 1'b1;
        end
      end else if (tgt_rsp_valid[u] && tgt_rsp[u].mst == CWX_MST_PCI0) begin
        tgt_rsp_ready[u] = pci_rsp_load[0];
      end else if (tgt_rsp_valid[u] && tgt_rsp[u].mst == CWX_MST_PCI1) begin
        tgt_rsp_ready[u] = pci_rsp_load[1];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpu_rsp_valid_reg <= 1'b0;
      cpu_rsp_reg       <= '0;
    end else if (cpu_rsp_load) begin
      cpu_rsp_valid_reg <= err_pend_reg || (|cpu_gnt);
      if (err_pend_reg) begin
        cpu_rsp_reg <= '{rdata: '0, err: 1'b1, mst: CWX_MST_CPU, cpu: err_cpu_reg};
      end else begin
        cpu_rsp_reg <= cpu_gnt_rsp;
      end
    end
  end

  for (genvar gp = 0; gp < CWX_NPCI; gp++) begin : g_prsp
    logic hit;
    assign hit = tgt_rsp_valid[CWX_U_REG] &&
                 tgt_rsp[CWX_U_REG].mst == (gp == 0 ? CWX_MST_PCI0 : CWX_MST_PCI1);
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        pci_rsp_valid_reg[gp] <= 1'b0;
        pci_rsp_reg[gp]       <= '0;
      end else if (pci_rsp_load[gp]) begin
        pci_rsp_valid_reg[gp] <= hit;
        pci_rsp_reg[gp]       <= tgt_rsp[CWX_U_REG];
      end
    end
    assign pci_rsp_valid[gp] = pci_rsp_valid_reg[gp];
    assign pci_rsp[gp]       = pci_rsp_reg[gp];
  end

  // Master role: transactions from internal units are driven onto the processor bus.
  assign mst_in_ready = !cpu_mst_valid_reg || cpu_mst_ready;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpu_mst_valid_reg <= 1'b0;
      cpu_mst_reg       <= '0;
    end else if (mst_in_ready) begin
      cpu_mst_valid_reg <= mst_in_valid;
      cpu_mst_reg       <= mst_in;
    end
  end

  assign cpu_rsp_valid = cpu_rsp_valid_reg;
  assign cpu_rsp       = cpu_rsp_reg;
  assign cpu_mst_valid = cpu_mst_valid_reg;
  assign cpu_mst       = cpu_mst_reg;
  assign unmapped      = unmapped_reg;
  assign dev_par       = dev_par_reg;

  sequence s_miss_take;
    cpu_take && miss;
  endsequence

  sequence s_err_out;
    cpu_rsp_valid_reg && cpu_rsp_reg.err;
  endsequence

  stall_at_eight_a: assert property (outst_reg[cpu_req.cpu] == CWX_MAX_OUTST
                                     |-> !cpu_req_ready)
    else $error("Address phase taken with eight transactions open");
  // A PCI port may load the register slot in the same cycle, so only processor loads count.
  miss_no_target_a: assert property (s_miss_take |->
                                     {load[CWX_NUNIT-2:0], cpu_reg_take} == '0)
    else $error("Unmapped access reached a target");
  miss_flag_a: assert property (s_miss_take |=> unmapped_reg)
    else $error("Unmapped access did not set the sticky flag");
  miss_answer_a: assert property (s_miss_take ##1 cpu_rsp_load |=> s_err_out)
    else $error("Unmapped access was not answered with an error");
  // Concurrent PCI loads of the register slot are legal; a processor access loads one unit.
  single_target_a: assert property ($onehot0({load[CWX_NUNIT-2:0], cpu_reg_take}))
    else $error("One cycle loaded more than one target");
  full_addr_a: assert property (cpu_take && !miss |=>
                                tgt_req_reg[$past(cpu_unit)].req.addr == $past(cpu_req.addr))
    else $error("Target address differs from the processor address");
  dev_param_a: assert property (load[CWX_U_DEV] |=>
                                tgt_req_reg[CWX_U_DEV].dpar == $past(cpu_dpar))
    else $error("Device request does not carry its bank parameters");
  bank_wide_rst_a: assert property ($fell(rst) |->
                                    dev_par_reg[0] == CWX_DEV_PAR_RST32 &&
                                    dev_par_reg[CWX_DEV_BOOT] == CWX_DEV_PAR_RST32)
    else $error("Boot bank or bank zero not 32-bit without parity after reset");
  bank_byte_rst_a: assert property ($fell(rst) |->
                                    dev_par_reg[CWX_DEV_BANK1] == CWX_DEV_PAR_RST8)
    else $error("Bank one not byte wide without parity after reset");
  pci_reg_a: assert property (pci_take[0] |=> tgt_valid_reg[CWX_U_REG] &&
                              tgt_req_reg[CWX_U_REG].mst == CWX_MST_PCI0)
    else $error("PCI port 0 request did not reach the register space");

endmodule

/* File: testbench/cwx_cpu_model.sv */
// Processor core model facing the processor port of the crossbar.
`timescale 1ns/1ns
module cwx_cpu_model (
  input  logic              ref_clk,
  input  logic              stall,
  output logic              cpu_req_valid,
  input  logic              cpu_req_ready,
  output cwx_pkg::cwx_req_s cpu_req,
  input  logic              cpu_rsp_valid,
  output logic              cpu_rsp_ready,
  input  cwx_pkg::cwx_rsp_s cpu_rsp,
  input  logic              cpu_mst_valid,
  output logic              cpu_mst_ready,
  input  cwx_pkg::cwx_req_s cpu_mst
);
  import cwx_pkg::*;
  cwx_rsp_s rsp_q [$];
  cwx_req_s mst_q [$];
  initial begin
    cpu_req_valid = 1'b0;
    cpu_req       = '0;
    cpu_rsp_ready = 1'b0;
    cpu_mst_ready = 1'b0;
  end
  always @(negedge ref_clk) begin
    cpu_rsp_ready = !stall;
    cpu_mst_ready = !stall;
  end
  always @(posedge ref_clk) begin
    if (cpu_rsp_valid === 1'b1 && cpu_rsp_ready)
      rsp_q.push_back(cpu_rsp);
    if (cpu_mst_valid === 1'b1 && cpu_mst_ready)
      mst_q.push_back(cpu_mst);
  end
  // Ready is looked at just before each rising edge; a released bus shows the inverse.
  task automatic send(input cwx_req_s r, input int lim, output bit ok);
    ok = 1'b0;
    @(negedge ref_clk);
    cpu_req_valid = 1'b1;
    cpu_req       = r;
    for (int i = 0; i < lim && !ok; i++) begin
      #24;
      ok = (cpu_req_ready === 1'b1);
      @(negedge ref_clk);
    end
    cpu_req_valid = 1'b0;
    cpu_req       = ~r;
  endtask
endmodule

/* File: testbench/tb_cwx_xbar.sv */
// Self-checking testbench of the processor-side window decoder crossbar.
`timescale 1ns/1ns
module tb_cwx_xbar;
  import cwx_pkg::*;
  logic         ref_clk = 1'b0;
  logic         rst = 1'b1;
  logic         stall = 1'b0;
  logic         cpu_req_valid, cpu_req_ready, cpu_rsp_valid, cpu_rsp_ready;
  logic         mst_in_valid, mst_in_ready, cpu_mst_valid, cpu_mst_ready;
  cwx_req_s     cpu_req, mst_in, cpu_mst;
  cwx_rsp_s     cpu_rsp;
  logic         pci_req_valid [CWX_NPCI];
  logic         pci_req_ready [CWX_NPCI];
  cwx_req_s     pci_req [CWX_NPCI];
  logic         pci_rsp_valid [CWX_NPCI];
  logic         pci_rsp_ready [CWX_NPCI];
  cwx_rsp_s     pci_rsp [CWX_NPCI];
  cwx_win_cfg_s win_cfg [CWX_NWIN];
  logic         dev_par_we, unmapped_clr, unmapped;
  logic [2:0]   dev_par_idx;
  cwx_dev_par_s dev_par_wdata;
  cwx_dev_par_s dev_par [CWX_NDEV];
  logic         tgt_valid [CWX_NUNIT];
  logic         tgt_ready [CWX_NUNIT];
  cwx_tgt_req_s tgt_req [CWX_NUNIT];
  logic         tgt_rsp_valid [CWX_NUNIT];
  logic         tgt_rsp_ready [CWX_NUNIT];
  cwx_rsp_s     tgt_rsp [CWX_NUNIT];
  logic         tk [CWX_NUNIT];
  logic         dn [CWX_NUNIT];
  cwx_tgt_req_s tq [CWX_NUNIT];
  int           tcyc [CWX_NUNIT];
  cwx_tgt_req_s last_t;
  int           takes, last_u, cyc, errors, tests_run;

  always #25 ref_clk = ~ref_clk;

  cwx_xbar i_dut (.ref_clk(ref_clk), .rst(rst), .cpu_req_valid(cpu_req_valid),
    .cpu_req_ready(cpu_req_ready), .cpu_req(cpu_req), .cpu_rsp_valid(cpu_rsp_valid),
    .cpu_rsp_ready(cpu_rsp_ready), .cpu_rsp(cpu_rsp), .mst_in_valid(mst_in_valid),
    .mst_in_ready(mst_in_ready), .mst_in(mst_in), .cpu_mst_valid(cpu_mst_valid),
    .cpu_mst_ready(cpu_mst_ready), .cpu_mst(cpu_mst), .pci_req_valid(pci_req_valid),
    .pci_req_ready(pci_req_ready), .pci_req(pci_req), .pci_rsp_valid(pci_rsp_valid),
    .pci_rsp_ready(pci_rsp_ready), .pci_rsp(pci_rsp), .win_cfg(win_cfg),
    .dev_par_we(dev_par_we), .dev_par_idx(dev_par_idx), .dev_par_wdata(dev_par_wdata),
    .dev_par(dev_par), .tgt_valid(tgt_valid), .tgt_ready(tgt_ready), .tgt_req(tgt_req),
    .tgt_rsp_valid(tgt_rsp_valid), .tgt_rsp_ready(tgt_rsp_ready), .tgt_rsp(tgt_rsp),
    .unmapped_clr(unmapped_clr), .unmapped(unmapped));

  cwx_cpu_model i_cpu (.ref_clk(ref_clk), .stall(stall), .cpu_req_valid(cpu_req_valid),
    .cpu_req_ready(cpu_req_ready), .cpu_req(cpu_req), .cpu_rsp_valid(cpu_rsp_valid),
    .cpu_rsp_ready(cpu_rsp_ready), .cpu_rsp(cpu_rsp), .cpu_mst_valid(cpu_mst_valid),
    .cpu_mst_ready(cpu_mst_ready), .cpu_mst(cpu_mst));

  // Target units: one request at a time, answered with its address plus the unit number.
  always @(posedge ref_clk) begin
    cyc++;
    for (int u = 0; u < CWX_NUNIT; u++) begin
      dn[u] = tgt_rsp_valid[u] && tgt_rsp_ready[u] === 1'b1;
      tk[u] = tgt_valid[u] === 1'b1 && tgt_ready[u];
      if (tk[u]) begin
        tq[u] = tgt_req[u];
        last_u = u;
        last_t = tgt_req[u];
        tcyc[u] = cyc;
        takes++;
      end
    end
  end
  always @(negedge ref_clk) begin
    for (int u = 0; u < CWX_NUNIT; u++) begin
      if (dn[u]) begin
        tgt_rsp_valid[u] = 1'b0;
        tgt_rsp[u] = ~tgt_rsp[u];
      end
      if (tk[u]) begin
        tgt_rsp_valid[u] = 1'b1;
        tgt_rsp[u] = '{rdata: 64'(tq[u].req.addr) + 64'(u), err: 1'b0, mst: tq[u].mst,
                       cpu: tq[u].req.cpu};
      end
      tgt_ready[u] = !tgt_rsp_valid[u];
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  function automatic cwx_req_s rq(input logic [35:0] a, input logic c);
    return '{addr: a, wdata: 64'h0, be: 8'hff, we: 1'b0, cpu: c};
  endfunction

  function automatic int wunit(input int w);
    return w < 4 ? 0 : w < 9 ? 1 : w < 14 ? 2 : w < 19 ? 3 : w - 15;
  endfunction

  task automatic cpu_rd(input logic [35:0] a, output cwx_rsp_s r, output int n);
    bit ok;
    int t0;
    t0 = takes;
    r = '0;
    i_cpu.send(rq(a, 1'b0), 20, ok);
    chk(ok, 1);
    for (int i = 0; i < 40 && i_cpu.rsp_q.size() == 0; i++)
      @(negedge ref_clk);
    chk(i_cpu.rsp_q.size(), 1);
    if (i_cpu.rsp_q.size() > 0)
      r = i_cpu.rsp_q.pop_front();
    n = takes - t0;
  endtask

  task automatic miss(input logic [35:0] a);
    cwx_rsp_s r;
    int n;
    cpu_rd(a, r, n);
    chk(n, 0);
    chk(r.err, 1);
    chk(unmapped, 1);
    unmapped_clr = 1'b1;
    @(negedge ref_clk);
    unmapped_clr = 1'b0;
    chk(unmapped, 0);
  endtask

  task automatic t_windows;
    cwx_rsp_s r;
    int n;
    logic [35:0] a;
    for (int w = 0; w < CWX_NWIN; w++) begin
      a = win_cfg[w].base + (w == 19 ? 36'h3_ffff : 36'h0fff_ffff);
      cpu_rd(a, r, n);
      chk(n, 1);
      chk(last_u, wunit(w));
      chk(last_t.win, w);
      chk(last_t.io, w == 13 || w == 18);
      chk(last_t.req.addr, a);
      chk({r.err, r.rdata[62:0]}, 64'(a) + 64'(wunit(w)));
    end
  endtask

  task automatic t_misses;
    cwx_rsp_s r;
    int n;
    miss(win_cfg[0].base + 36'h1000_0000);
    miss(win_cfg[19].base + 36'h4_0000);
    miss(36'h8_0000_0000);
    win_cfg[4].size_m1 = 32'hffff_ffff;
    win_cfg[1].en = 1'b0;
    miss(win_cfg[1].base);
    miss(win_cfg[4].base + 36'h2000_0000);
    cpu_rd(win_cfg[4].base + 36'h1fff_fff8, r, n);
    chk(n, 1);
    win_cfg[4].size_m1 = 32'h0fff_ffff;
    win_cfg[1].en = 1'b1;
    win_cfg[19].base = win_cfg[0].base;
    cpu_rd(win_cfg[0].base + 36'h100, r, n);
    chk(n, 1);
    chk(last_t.win, 0);
    win_cfg[19].base = 36'(19) << 30;
  endtask

  task automatic t_devpar;
    cwx_dev_par_s p;
    cwx_dev_par_s e;
    cwx_rsp_s r;
    int n;
    p = '{width: CWX_W16, parity_en: 1'b1, wait_cyc: 4'h3};
    for (int k = 5; k > 0; k -= 4) begin
      dev_par_idx = 3'(k);
      dev_par_wdata = p;
      dev_par_we = 1'b1;
      @(negedge ref_clk);
      dev_par_we = 1'b0;
      for (int b = 0; b < CWX_NDEV; b++) begin
        e = b == 1 ? CWX_DEV_PAR_RST8 : CWX_DEV_PAR_RST32;
        chk(dev_par[b], b == k ? p : e);
      end
    end
    cpu_rd(win_cfg[5].base, r, n);
    chk(last_t.dpar, p);
  endtask

  task automatic pci_send(input int p, input logic [35:0] a);
    bit ok;
    ok = 1'b0;
    @(negedge ref_clk);
    pci_req_valid[p] = 1'b1;
    pci_req[p] = rq(a, 1'b0);
    for (int i = 0; i < 20 && !ok; i++) begin
      #24;
      ok = pci_req_ready[p] === 1'b1;
      @(negedge ref_clk);
    end
    pci_req_valid[p] = 1'b0;
    pci_req[p] = ~pci_req[p];
    for (int i = 0; i < 40 && pci_rsp_valid[p] !== 1'b1; i++)
      @(negedge ref_clk);
    chk(pci_rsp[p].rdata, 64'(a) + 64'h5);
    chk(pci_rsp[p].mst, p + 1);
  endtask

  task automatic t_pci;
    cwx_rsp_s r;
    int n;
    pci_send(0, win_cfg[20].base + 36'h10);
    pci_send(1, win_cfg[20].base + 36'h20);
    fork
      cpu_rd(win_cfg[0].base, r, n);
      pci_send(1, win_cfg[20].base);
    join
    chk(tcyc[0], tcyc[5]);
  endtask

  task automatic t_outst;
    int ww [5] = '{0, 4, 9, 14, 19};
    int acc;
    bit ok;
    acc = 0;
    i_cpu.rsp_q.delete();
    stall = 1'b1;
    for (int i = 0; i < 9; i++) begin
      i_cpu.send(rq(win_cfg[ww[i % 5]].base, 1'b0), 10, ok);
      acc += ok;
    end
    chk(acc, 8);
    i_cpu.send(rq(win_cfg[19].base, 1'b1), 10, ok);
    chk(ok, 1);
    stall = 1'b0;
    for (int i = 0; i < 200 && i_cpu.rsp_q.size() < 9; i++)
      @(negedge ref_clk);
    chk(i_cpu.rsp_q.size(), 9);
  endtask

  task automatic t_mst;
    bit ok;
    ok = 1'b0;
    i_cpu.mst_q.delete();
    mst_in = rq(36'h1_2345_6788, 1'b1);
    mst_in_valid = 1'b1;
    for (int i = 0; i < 20 && !ok; i++) begin
      #24;
      ok = mst_in_ready === 1'b1;
      @(negedge ref_clk);
    end
    mst_in_valid = 1'b0;
    mst_in = ~mst_in;
    @(negedge ref_clk);
    chk(i_cpu.mst_q.size(), 1);
    if (i_cpu.mst_q.size() > 0)
      chk(i_cpu.mst_q[0].addr, 36'h1_2345_6788);
  endtask

  initial begin
    for (int w = 0; w < CWX_NWIN; w++)
      win_cfg[w] = '{en: 1'b1, base: 36'(w) << 30, size_m1: 32'h0fff_ffff};
    for (int u = 0; u < CWX_NUNIT; u++) begin
      tgt_ready[u] = 1'b1;
      tgt_rsp_valid[u] = 1'b0;
      tgt_rsp[u] = '0;
      tk[u] = 1'b0;
      dn[u] = 1'b0;
    end
    for (int p = 0; p < CWX_NPCI; p++) begin
      pci_req_valid[p] = 1'b0;
      pci_req[p] = '0;
      pci_rsp_ready[p] = 1'b1;
    end
    {mst_in_valid, dev_par_we, unmapped_clr, dev_par_idx} = '0;
    mst_in = '0;
    dev_par_wdata = '0;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    chk({cpu_rsp_valid, unmapped}, 0);
    t_windows;
    t_misses;
    t_devpar;
    t_pci;
    t_outst;
    t_mst;
    finish_test;
  end

  initial begin
    #(50 * 20000);
    errors++;
    finish_test;
  end
endmodule
